// ===== hdl/cgoc_pkg.sv
// constants for the column gain/offset correction block
// assumes a single pixel clock shared by the stream and the register bus
package cgoc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] REG_CTRL   = 8'h00; // enable, coefficient mode
  localparam logic [7:0] REG_STATUS = 8'h04; // frame-active settings, error flag
  localparam logic [7:0] REG_COL    = 8'h08; // table column index
  localparam logic [7:0] REG_GAIN   = 8'h0c; // user gain at selected column
  localparam logic [7:0] REG_OFFSET = 8'h10; // user offset at selected column
  localparam logic [7:0] REG_CMD    = 8'h14; // restore / save strobes, write only
  localparam logic [7:0] REG_STEP   = 8'h18; // offset step size, read only
  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int STAT_ERR_BIT   = 3;
  localparam int CMD_RESTORE    = 0;
  localparam int CMD_SAVE       = 1;
  // widths and reset values
  localparam int PIX_W          = 16;
  localparam int COEF_W         = 16;
  localparam int GAIN_FRAC      = 12; // gain is unsigned 4.12
  localparam logic [15:0] GAIN_UNITY  = 16'h1000;
  localparam logic [15:0] OFFSET_ZERO = 16'h0000;
  localparam logic [15:0] OFFSET_STEP = 16'h0020;
  localparam logic        EN_RESET    = 1'b1;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [1:0]  RESP_DECERR = 2'b11;
  // coefficient modes
  typedef enum logic [1:0] {MODE_FACTORY, MODE_USER, MODE_CALIB} cgoc_mode_t;
endpackage : cgoc_pkg

// ===== hdl/stream_if.sv
// valid/ready word channel joining the block to its input fifo
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int W = 18);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// ===== hdl/pixel_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes the pusher honours in_ready_o and the drainer honours out.valid
`timescale 1ns/100ps
`default_nettype none
module pixel_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output var  logic         in_ready_o,
  stream_if.source          out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = out.valid && out.ready;
  assign out.valid = (cnt_q != '0);
  assign out.data  = mem_q[rd_q];

  // occupancy count and registered space flag
  always_comb begin
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  // storage and pointers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

  property p_no_overflow;
    @(posedge mclk_i) disable iff (srst_i) cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo over depth");
endmodule : pixel_fifo
`default_nettype wire

// ===== hdl/column_gain_offset_correction.sv
// per-column gain/offset correction of a pixel stream, axi4-lite registers
// assumes a synchronous ROM of factory coefficients with one cycle latency
// Contract
// - each pixel becomes gain times the sum of its value and the offset.
// - gain and offset are chosen by the pixel's column, and in factory mode also by the gain level.
// - software switches correction on or off and it starts switched on.
// - three coefficient modes exist and factory is chosen at reset.
// - factory mode uses factory coefficients picked by camera gain level.
// - user mode uses one user table whose default gives no correction.
// - calibration mode forces correction off and opens the user table.
// - calibration edits act only after user mode and enable are set again.
// - user table access is refused outside calibration mode.
// - a column index selects which table entry the gain and offset access.
// - offsets are 16 bit in steps of a readable size; other values error.
// - restore reloads the saved table, or the no-correction defaults.
// - save copies the user table to retained storage, replacing the old.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module column_gain_offset_correction #(
  parameter int NCOLS  = 64,
  parameter int LVL_W  = 2,
  parameter int FIFO_D = 16
) (
  input  wire logic                              mclk_i,
  input  wire logic                              srst_i,
  // pixel stream in
  input  wire logic                              pix_valid_i,
  input  wire logic [cgoc_pkg::PIX_W-1:0]        pix_data_i,
  input  wire logic                              pix_sof_i,
  input  wire logic                              pix_eol_i,
  output var  logic                              pix_ready_o,
  // pixel stream out
  output var  logic                              out_valid_o,
  output var  logic [cgoc_pkg::PIX_W-1:0]        out_data_o,
  output var  logic                              out_sof_o,
  output var  logic                              out_eol_o,
  input  wire logic                              out_ready_i,
  // camera gain level and factory coefficient rom
  input  wire logic [LVL_W-1:0]                  gain_level_i,
  output var  logic [LVL_W+$clog2(NCOLS)-1:0]    factory_addr_o,
  input  wire logic [cgoc_pkg::COEF_W-1:0]       factory_gain_i,
  input  wire logic [cgoc_pkg::COEF_W-1:0]       factory_offset_i,
  // axi4-lite slave
  input  wire logic                              s_axi_awvalid,
  output var  logic                              s_axi_awready,
  input  wire logic [7:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_wvalid,
  output var  logic                              s_axi_wready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  output var  logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  output var  logic [1:0]                        s_axi_bresp,
  input  wire logic                              s_axi_arvalid,
  output var  logic                              s_axi_arready,
  input  wire logic [7:0]                        s_axi_araddr,
  output var  logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output var  logic [31:0]                       s_axi_rdata,
  output var  logic [1:0]                        s_axi_rresp
);
  import cgoc_pkg::*;
  localparam int CW = $clog2(NCOLS);
  localparam int FW = PIX_W + 2;

  stream_if #(.W(FW)) fq ();

  // every check below runs on the pixel clock and rests during reset
  default clocking cb_chk @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  logic [COEF_W-1:0] gain_q [NCOLS];
  logic [COEF_W-1:0] off_q  [NCOLS];
  logic [COEF_W-1:0] sgain_q [NCOLS];
  logic [COEF_W-1:0] soff_q  [NCOLS];
  logic              saved_q;
  logic              en_q, act_en_q, err_q;
  cgoc_mode_t        mode_q, act_mode_q;
  logic [CW-1:0]     col_sel_q, col_nx_q, a_col_q;
  logic [LVL_W-1:0]  lvl_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              a_v_q, a_ok_q, a_sof_q, a_eol_q;
  logic [PIX_W-1:0]  a_pix_q;
  logic              adv, fire, pop, wr_fire, wr_ok, tbl_wr;
  logic [CW-1:0]     pop_col;
  logic [COEF_W-1:0] g_sel, o_sel;
  logic [PIX_W-1:0]  corr;
  logic signed [PIX_W+1:0] sum;
  logic [PIX_W+COEF_W:0]   prod;

  // input fifo; its space flag stalls the sensor side
  pixel_fifo #(.W(FW), .DEPTH(FIFO_D)) u_fifo (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .in_valid_i (pix_valid_i),
    .in_data_i  ({pix_sof_i, pix_eol_i, pix_data_i}),
    .in_ready_o (pix_ready_o),
    .out        (fq.source)
  );

  // stage a holds a pixel until its rom word is in and the output register is free
  assign adv      = !out_valid_o || out_ready_i;
  assign fire     = a_v_q && a_ok_q && adv;
  assign fq.ready = !a_v_q || fire;
  assign pop      = fq.valid && fq.ready;
  assign pop_col  = fq.data[FW-1] ? '0 : col_nx_q; // column restarts at frame start

  // column counter and stage a capture; a_ok_q marks the rom word as arrived
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      col_nx_q <= '0;
      a_v_q    <= 1'b0;
      a_ok_q   <= 1'b0;
      a_sof_q  <= 1'b0;
      a_eol_q  <= 1'b0;
      a_pix_q  <= '0;
      a_col_q  <= '0;
    end else if (pop) begin
      a_v_q    <= 1'b1;
      a_ok_q   <= 1'b0;
      a_sof_q  <= fq.data[FW-1];
      a_eol_q  <= fq.data[FW-2];
      a_pix_q  <= fq.data[PIX_W-1:0];
      a_col_q  <= pop_col;
      col_nx_q <= fq.data[FW-2] ? '0 : pop_col + 1'b1;
    end else begin
      a_v_q  <= a_v_q && !fire;
      a_ok_q <= a_v_q && !fire;
    end
  end

  // active settings latched only with the first pixel of a frame
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      act_en_q   <= EN_RESET;
      act_mode_q <= MODE_FACTORY;
      lvl_q      <= '0;
    end else if (pop && fq.data[FW-1]) begin
      act_en_q   <= en_q && (mode_q != MODE_CALIB);
      act_mode_q <= mode_q;
      lvl_q      <= gain_level_i;
    end
  end

  // factory rom address: gain level and column
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      factory_addr_o <= '0;
    end else if (pop) begin
      factory_addr_o <= {(fq.data[FW-1] ? gain_level_i : lvl_q), pop_col};
    end
  end

  // coefficient choice and arithmetic with clamping
  always_comb begin
    g_sel = (act_mode_q == MODE_FACTORY) ? factory_gain_i : gain_q[a_col_q];
    o_sel = (act_mode_q == MODE_FACTORY) ? factory_offset_i : off_q[a_col_q];
    sum   = $signed({2'b00, a_pix_q}) + $signed({{2{o_sel[COEF_W-1]}}, o_sel});
    prod  = sum[PIX_W+1] ? '0 : (PIX_W+COEF_W+1)'(sum[PIX_W:0] * g_sel);
    if (!act_en_q) begin
      corr = a_pix_q;
    end else if (|prod[PIX_W+COEF_W:PIX_W+GAIN_FRAC]) begin
      corr = '1;
    end else begin
      corr = prod[PIX_W+GAIN_FRAC-1:GAIN_FRAC];
    end
  end

  // output register
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      out_sof_o   <= 1'b0;
      out_eol_o   <= 1'b0;
    end else if (fire) begin
      out_valid_o <= 1'b1;
      out_data_o  <= corr;
      out_sof_o   <= a_sof_q;
      out_eol_o   <= a_eol_q;
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  // write channel: address and data held until both present
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign tbl_wr  = (aw_addr_q == REG_GAIN) || (aw_addr_q == REG_OFFSET);
  assign wr_ok   = !tbl_wr || (mode_q == MODE_CALIB);
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q > REG_STEP || aw_addr_q[1:0] != 2'b00) begin
          s_axi_bresp <= RESP_DECERR;
        end else if (!wr_ok || (aw_addr_q == REG_OFFSET && (w_data_q[15:0] % OFFSET_STEP) != 0)) begin
          s_axi_bresp <= RESP_SLVERR;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // control registers; calibration clears the enable so it must be set again
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      en_q      <= EN_RESET;
      mode_q    <= MODE_FACTORY;
      col_sel_q <= '0;
      err_q     <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr_q == REG_CTRL && w_strb_q[0]) begin
        if (w_data_q[CTRL_MODE_LSB+:2] != 2'b11) begin
          mode_q <= cgoc_mode_t'(w_data_q[CTRL_MODE_LSB+:2]);
        end
        en_q <= w_data_q[CTRL_EN_BIT] && (w_data_q[CTRL_MODE_LSB+:2] != MODE_CALIB)
                && (mode_q != MODE_CALIB || w_data_q[CTRL_MODE_LSB+:2] != 2'b11);
      end
      if (aw_addr_q == REG_COL && w_strb_q[0]) begin
        col_sel_q <= w_data_q[CW-1:0];
      end
      if (aw_addr_q == REG_OFFSET && wr_ok && (w_data_q[15:0] % OFFSET_STEP) != 0) begin
        err_q <= 1'b1;
      end else if (aw_addr_q == REG_STATUS && w_data_q[STAT_ERR_BIT]) begin
        err_q <= 1'b0; // write one to clear
      end
    end
  end

  // user table, its retained copy, restore and save
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      saved_q <= 1'b0;
      for (int i = 0; i < NCOLS; i++) begin
        gain_q[i] <= GAIN_UNITY;
        off_q[i]  <= OFFSET_ZERO;
      end
    end else if (wr_fire && wr_ok) begin
      if (aw_addr_q == REG_GAIN && w_strb_q[1:0] == 2'b11) begin
        gain_q[col_sel_q] <= w_data_q[15:0];
      end
      if (aw_addr_q == REG_OFFSET && w_strb_q[1:0] == 2'b11
          && (w_data_q[15:0] % OFFSET_STEP) == 0) begin
        off_q[col_sel_q] <= w_data_q[15:0];
      end
      if (aw_addr_q == REG_CMD && w_data_q[CMD_RESTORE]) begin
        for (int i = 0; i < NCOLS; i++) begin
          gain_q[i] <= saved_q ? sgain_q[i] : GAIN_UNITY;
          off_q[i]  <= saved_q ? soff_q[i] : OFFSET_ZERO;
        end
      end else if (aw_addr_q == REG_CMD && w_data_q[CMD_SAVE]) begin
        saved_q <= 1'b1;
      end
    end
  end

  // retained copy has no reset: it stands for storage kept over power loss
  always_ff @(posedge mclk_i) begin
    if (wr_fire && aw_addr_q == REG_CMD && !w_data_q[CMD_RESTORE] && w_data_q[CMD_SAVE]) begin
      for (int i = 0; i < NCOLS; i++) begin
        sgain_q[i] <= gain_q[i];
        soff_q[i]  <= off_q[i];
      end
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata <= {29'h0, mode_q, en_q};
        REG_STATUS: s_axi_rdata <= {28'h0, err_q, act_mode_q, act_en_q};
        REG_COL:    s_axi_rdata <= 32'(col_sel_q);
        REG_GAIN, REG_OFFSET: begin
          if (mode_q == MODE_CALIB) begin
            s_axi_rdata <= {16'h0, (s_axi_araddr == REG_GAIN) ? gain_q[col_sel_q]
                                                               : off_q[col_sel_q]};
          end else begin
            s_axi_rresp <= RESP_SLVERR;
          end
        end
        REG_CMD:    s_axi_rdata <= '0;
        REG_STEP:   s_axi_rdata <= {16'h0, OFFSET_STEP};
        default:    s_axi_rresp <= RESP_DECERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  sequence s_wr(logic [7:0] a);
    wr_fire && aw_addr_q == a;
  endsequence
  sequence s_sof_pop;
    pop && fq.data[FW-1];
  endsequence

  property p_rst_defaults;
    $past(srst_i) && !srst_i |-> en_q && mode_q == MODE_FACTORY;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("bad reset");
  property p_calib_off;
    mode_q == MODE_CALIB |-> !en_q;
  endproperty
  a_calib_off: assert property (p_calib_off) else $error("enable set in calibration");
  property p_tbl_refused;
    s_wr(REG_GAIN) and (mode_q != MODE_CALIB) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_tbl_refused: assert property (p_tbl_refused) else $error("table write let in");
  property p_step_err;
    s_wr(REG_OFFSET) and (mode_q == MODE_CALIB) and (w_data_q[4:0] != 5'h00) |=> err_q;
  endproperty
  a_step_err: assert property (p_step_err) else $error("bad offset not flagged");
  property p_frame_only;
    !(pop && fq.data[FW-1]) |=> $stable(act_mode_q) && $stable(act_en_q);
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("changed mid frame");
  property p_sof_latch;
    s_sof_pop |=> act_mode_q == $past(mode_q);
  endproperty
  a_sof_latch: assert property (p_sof_latch) else $error("mode not latched");
  property p_restore_default;
    s_wr(REG_CMD) and w_data_q[CMD_RESTORE] and !saved_q and wr_ok
      |=> gain_q[col_sel_q] == GAIN_UNITY && off_q[col_sel_q] == OFFSET_ZERO;
  endproperty
  a_restore_default: assert property (p_restore_default) else $error("bad restore");
  property p_save;
    s_wr(REG_CMD) and w_data_q[CMD_SAVE] and !w_data_q[CMD_RESTORE]
      |=> saved_q && sgain_q[col_sel_q] == $past(gain_q[col_sel_q]);
  endproperty
  a_save: assert property (p_save) else $error("save did not copy table");
  property p_bypass;
    fire && !act_en_q |=> out_valid_o && out_data_o == $past(a_pix_q);
  endproperty
  a_bypass: assert property (p_bypass) else $error("disabled pixel altered");
  property p_rom_wait;
    pop |=> !fire;
  endproperty
  a_rom_wait: assert property (p_rom_wait) else $error("pixel left before rom word");
endmodule : column_gain_offset_correction
`default_nettype wire

// ===== verification/rom_fn_pkg.sv
// factory coefficient contents shared by the rom model and the bench
// assumes an address of {gain level, column}
package rom_fn_pkg;
  function automatic logic [15:0] rom_g(input logic [7:0] a);
    return 16'h0e00 + {6'h00, a, 2'h0};
  endfunction : rom_g
  function automatic logic [15:0] rom_o(input logic [7:0] a);
    return {8'h00, a} - 16'h0040;
  endfunction : rom_o
endpackage : rom_fn_pkg

// ===== verification/factory_rom.sv
// synchronous factory coefficient rom model
// assumes the block registers its address and reads one cycle later
`timescale 1ns/100ps
`default_nettype none
module factory_rom
  import rom_fn_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [7:0]  addr_i,
  output var  logic [15:0] gain_o,
  output var  logic [15:0] offset_o
);
  // one cycle read latency
  always_ff @(posedge mclk_i) begin
    gain_o   <= rom_g(addr_i);
    offset_o <= rom_o(addr_i);
  end
endmodule : factory_rom
`default_nettype wire

// ===== verification/column_gain_offset_correction_tb.sv
// self-checking bench: axi4-lite master, pixel source and sink, rom model
// assumes one 25 MHz clock and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module column_gain_offset_correction_tb;
  import cgoc_pkg::*;
  import rom_fn_pkg::*;
  logic        mclk_i = 0, srst_i = 1, pv = 0, ps = 0, pe = 0, ordy = 0;
  logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, m_en = 1, a_en = 1;
  logic        prdy, ov, osof, oeol, awr, wr, bv, arr, rv;
  logic [15:0] pd = 16'h0000, od, fg, fo;
  logic [1:0]  lvl = 2'h0, gl = 2'h0, br, rr;
  logic [7:0]  awa = 8'h00, ara = 8'h00, fa;
  logic [31:0] wda = 32'h0, rd, seed = 32'h088c, rs = 32'h088c;
  logic [5:0]  mc = 6'h00;
  logic [15:0] ug[64], uo[64], sg[64], so[64];
  logic [17:0] q[$];
  logic        svd = 0;
  int          fails = 0, cmp_count = 0, omode = 0;
  int          cs[3] = '{0, 1, 63};
  logic [15:0] gs[3] = '{16'h2000, 16'h1800, 16'h0c00};
  logic [15:0] os[3] = '{16'h0040, 16'hffe0, 16'h0ae0};
  cgoc_mode_t  m_mode = MODE_FACTORY, a_mode = MODE_FACTORY;
  always #20 mclk_i = ~mclk_i;
  column_gain_offset_correction i_column_gain_offset_correction (
    .mclk_i(mclk_i), .srst_i(srst_i), .pix_valid_i(pv), .pix_data_i(pd),
    .pix_sof_i(ps), .pix_eol_i(pe), .pix_ready_o(prdy), .out_valid_o(ov),
    .out_data_o(od), .out_sof_o(osof), .out_eol_o(oeol), .out_ready_i(ordy),
    .gain_level_i(lvl), .factory_addr_o(fa), .factory_gain_i(fg),
    .factory_offset_i(fo), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wda),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr));
  factory_rom i_factory_rom (.mclk_i(mclk_i), .addr_i(fa), .gain_o(fg), .offset_o(fo));
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected corrected pixel with clamping
  function automatic logic [15:0] corr(input logic [15:0] u, g, o);
    longint s;
    s = longint'(u) + longint'($signed(o));
    if (s < 0) s = 0;
    s = (s * longint'(g)) >>> 12;
    if (s > 65535) s = 65535;
    return 16'(s);
  endfunction : corr
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic tmo();
    fails++;
    end_of_test();
  endtask : tmo
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_pix(input logic [17:0] g, input logic [17:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t pixel got %h exp %h", $time, g, e);
    end
  endtask : cmp_pix
  // register write, then the bench's own copy of the control state
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge mclk_i);
    awv <= 1; wv <= 1; awa <= a; wda <= d; bre <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (awv && awr === 1'b1) awv <= 0;
      if (wv && wr === 1'b1) wv <= 0;
      if (bv === 1'b1) break;
    end
    if (n == 100) tmo();
    bre <= 0;
    cmp(32'(br), 32'(e));
    if (e == RESP_OKAY) begin
      case (a)
        REG_CTRL: begin
          if (d[2:1] != 2'b11) m_mode = cgoc_mode_t'(d[2:1]);
          m_en = (m_mode != MODE_CALIB) && d[0];
        end
        REG_COL: mc = d[5:0];
        REG_GAIN: ug[mc] = d[15:0];
        REG_OFFSET: uo[mc] = d[15:0];
        REG_CMD: if (d[0] && svd) begin
          ug = sg;
          uo = so;
        end else if (d[0]) begin
          foreach (ug[i]) ug[i] = GAIN_UNITY;
          foreach (uo[i]) uo[i] = OFFSET_ZERO;
        end else if (d[1]) begin
          sg = ug;
          so = uo;
          svd = 1;
        end
        default: ;
      endcase
    end
  endtask : axw
  // register read; data is checked only on an okay answer
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
    int n;
    @(posedge mclk_i);
    arv <= 1; ara <= a; rre <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (arv && arr === 1'b1) arv <= 0;
      if (rv === 1'b1) break;
    end
    if (n == 100) tmo();
    rre <= 0;
    cmp(32'(rr), 32'(e));
    if (e == RESP_OKAY) cmp(rd, ed);
  endtask : axr
  // offer one pixel and queue its expected result
  task automatic push(input logic [15:0] u, input logic s, input logic l, input int c);
    int n;
    logic [15:0] e;
    pv <= 1; pd <= u; ps <= s; pe <= l;
    if (s) begin
      a_en = m_en;
      a_mode = m_mode;
    end
    if (!a_en || a_mode == MODE_CALIB) e = u;
    else if (a_mode == MODE_USER) e = corr(u, ug[c], uo[c]);
    else e = corr(u, rom_g({gl, 6'(c)}), rom_o({gl, 6'(c)}));
    q.push_back({s, l, e});
    for (n = 0; n < 500; n++) begin
      @(posedge mclk_i);
      if (prdy === 1'b1) break;
    end
    if (n == 500) tmo();
  endtask : push
  // a frame whose first two pixels hit the clamps
  task automatic frame(input int nc, input int nl);
    for (int l = 0; l < nl; l++) begin
      for (int c = 0; c < nc; c++) begin
        seed = xs(seed);
        push((l == 0 && c < 2) ? {16{c == 0}} : seed[15:0], l == 0 && c == 0, c == nc - 1, c);
      end
    end
    pv <= 0;
  endtask : frame
  task automatic drain();
    int n;
    for (n = 0; n < 3000 && q.size() > 0; n++) @(posedge mclk_i);
    if (q.size() > 0) tmo();
  endtask : drain
  task automatic tbl();
    for (int i = 0; i < 3; i++) begin
      axw(REG_COL, 32'(cs[i]), RESP_OKAY);
      axw(REG_GAIN, {16'h0, gs[i]}, RESP_OKAY);
      axw(REG_OFFSET, {16'h0, os[i]}, RESP_OKAY);
      axr(REG_GAIN, {16'h0, gs[i]}, RESP_OKAY);
    end
  endtask : tbl
  // output checker and random back-pressure
  always @(posedge mclk_i) begin
    if (!srst_i && ov === 1'b1 && ordy === 1'b1) begin
      if (q.size() == 0) cmp_pix({osof, oeol, od}, 18'h3ffff);
      else cmp_pix({osof, oeol, od}, q.pop_front());
    end
    rs = xs(rs);
    ordy <= (omode == 0) ? rs[3] : (omode == 2);
  end
  // main sequence
  initial begin
    foreach (ug[i]) ug[i] = GAIN_UNITY;
    foreach (uo[i]) uo[i] = OFFSET_ZERO;
    repeat (16) @(posedge mclk_i);
    srst_i <= 0;
    axr(REG_CTRL, 32'h1, RESP_OKAY);
    axr(REG_STEP, {16'h0, OFFSET_STEP}, RESP_OKAY);
    axr(REG_GAIN, 32'h0, RESP_SLVERR);
    axw(REG_OFFSET, 32'h20, RESP_SLVERR);
    axw(REG_GAIN, 32'h2000, RESP_SLVERR);
    axr(8'h1c, 32'h0, RESP_DECERR);
    for (int k = 0; k < 4; k++) begin
      gl = 2'(k);
      lvl <= gl;
      frame(8, 2);
      drain();
    end
    axw(REG_CTRL, 32'h5, RESP_OKAY);
    axr(REG_CTRL, 32'h4, RESP_OKAY);
    tbl();
    axw(REG_CMD, 32'h1, RESP_OKAY);
    axr(REG_GAIN, 32'h1000, RESP_OKAY);
    tbl();
    axw(REG_CMD, 32'h2, RESP_OKAY);
    axw(REG_GAIN, 32'h3000, RESP_OKAY);
    axw(REG_CMD, 32'h1, RESP_OKAY);
    axr(REG_GAIN, {16'h0, gs[2]}, RESP_OKAY);
    axw(REG_OFFSET, 32'h21, RESP_SLVERR);
    axr(REG_OFFSET, {16'h0, os[2]}, RESP_OKAY);
    axr(REG_STATUS, 32'h9, RESP_OKAY);
    axw(REG_STATUS, 32'h8, RESP_OKAY);
    axr(REG_STATUS, 32'h1, RESP_OKAY);
    frame(64, 2);
    drain();
    axw(REG_CTRL, 32'h3, RESP_OKAY);
    frame(64, 2);
    drain();
    omode = 2;
    fork
      frame(64, 1);
      begin
        repeat (10) @(posedge mclk_i);
        axw(REG_CTRL, 32'h2, RESP_OKAY);
      end
    join
    drain();
    frame(8, 1);
    drain();
    omode = 1;
    fork
      frame(24, 1);
      begin
        repeat (80) @(posedge mclk_i);
        cmp(32'(prdy), 32'h0);
        cmp(32'(q.size() > 16 && q.size() < 22), 32'h1);
        omode = 0;
      end
    join
    drain();
    end_of_test();
  end
endmodule : column_gain_offset_correction_tb
`default_nettype wire
